// [hdl/jtag_test_data_registers.v]
// What this block does
// - Opcodes 8..B are private debug instructions, flagged on a port.
// - CPU write stores the byte and sets the dirty flag together.
// - CPU read returns low seven stored bits plus dirty flag on top.
// - Shared location reaches the register only with fuse and enable.
// - Test port works only with enable fuse and disable bit clear.
// - Lock bits block debug fuse programming until chip erase.
// - Instruction register selects IDCODE after power-up.
// - Entering reset floats every port pin output at once, unless EXTEST is driving the pins.
// - EXTEST drives latches to pins at once and samples pins.
// - SAMPLE/PRELOAD snapshots pins without disturbing operation.
// - Scan runs on the chip clock; test clock must stay below clk_i/4.
// - Bypass is one stage cleared to zero in Capture-DR.
// - ID: version 31..28, part 27..12, maker 11..1, bit 0 one.
// - Version field follows silicon revision.
// - One in reset register holds device reset, unlatched.
// - After release, reset lasts the fused time-out period.
// - Programming needs only the four test pins, no high voltage.
// - IR is four bits: EXTEST 0, IDCODE 1, SAMPLE 2, reset C, BYPASS F.
// - All shift registers move LSB first in and out.
`timescale 1ns/1ps
`include "tdr_defs.vh"
module jtag_test_data_registers #(
    parameter [3:0] SILICON_REV = 4'h0
) (
    input  wire                 clk_i,
    input  wire                 reset_n_i,
    input  wire                 tck_i,
    input  wire                 tms_i,
    input  wire                 tdi_i,
    output wire                 tdo_o,
    output wire                 tdo_oe_o,
    input  wire                 test_port_enable_fuse_i,
    input  wire                 test_port_disable_bit_i,
    input  wire                 debug_enable_fuse_i,
    input  wire                 lock_bit_one_i,
    input  wire                 lock_bit_two_i,
    input  wire                 chip_erase_i,
    input  wire                 fuse_prog_req_i,
    output wire                 fuse_prog_ok_o,
    input  wire                 dbg_access_en_i,
    input  wire                 dbg_dirty_clr_i,
    output wire [`COMM_W-1:0]   dbg_comm_data_o,
    input  wire                 cpu_sel_i,
    input  wire                 cpu_wr_i,
    input  wire                 cpu_rd_i,
    input  wire [`COMM_W-1:0]   cpu_wdata_i,
    output wire [`COMM_W-1:0]   cpu_rdata_o,
    output wire                 io_reg_sel_o,
    input  wire [`BSR_W-1:0]    pin_in_i,
    input  wire [`BSR_W-1:0]    core_out_i,
    input  wire [`BSR_W-1:0]    core_oe_i,
    output wire [`BSR_W-1:0]    pin_out_o,
    output wire [`BSR_W-1:0]    pin_oe_o,
    output wire                 private_op_o,
    output wire [1:0]           private_sel_o,
    output wire                 dev_reset_o,
    input  wire [`TO_W-1:0]     reset_timeout_i
);
    // ----------------------------------------
    // Pin synchronisation and test clock edge
    // ----------------------------------------
    wire [2:0] tap_sync;
    reg        tck_prev_q;
    wire       tck_rise;
    wire       tck_fall;
    wire       tap_en;

    pin_sync #(.W(3)) u_sync (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .async_i   ({tck_i, tms_i, tdi_i}),
        .sync_o    (tap_sync)
    );

    // Edge finder on synchronised test clock
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            tck_prev_q <= 1'b0;
        end else begin
            tck_prev_q <= tap_sync[2];
        end
    end
    assign tck_rise = tap_sync[2] & ~tck_prev_q;
    assign tck_fall = ~tap_sync[2] & tck_prev_q;

    // Port alive only with fuse set and disable bit clear
    assign tap_en = test_port_enable_fuse_i & ~test_port_disable_bit_i;

    // ----------------------------------------
    // TAP controller
    // ----------------------------------------
    // Test clock is sampled by the chip clock, so it must stay below
    // clk_i/4; a fast-TCK domain was traded for one-clock simplicity.
    reg [3:0] st_q;
    reg [3:0] st_d;
    wire      tms = tap_sync[1];
    wire      tdi = tap_sync[0];

    always @* begin
        st_d = st_q;
        case (st_q)
            `ST_RESET:  st_d = tms ? `ST_RESET  : `ST_IDLE;
            `ST_IDLE:   st_d = tms ? `ST_SEL_DR : `ST_IDLE;
            `ST_SEL_DR: st_d = tms ? `ST_SEL_IR : `ST_CAP_DR;
            `ST_CAP_DR: st_d = tms ? `ST_EX1_DR : `ST_SH_DR;
            `ST_SH_DR:  st_d = tms ? `ST_EX1_DR : `ST_SH_DR;
            `ST_EX1_DR: st_d = tms ? `ST_UPD_DR : `ST_PAU_DR;
            `ST_PAU_DR: st_d = tms ? `ST_EX2_DR : `ST_PAU_DR;
            `ST_EX2_DR: st_d = tms ? `ST_UPD_DR : `ST_SH_DR;
            `ST_UPD_DR: st_d = tms ? `ST_SEL_DR : `ST_IDLE;
            `ST_SEL_IR: st_d = tms ? `ST_RESET  : `ST_CAP_IR;
            `ST_CAP_IR: st_d = tms ? `ST_EX1_IR : `ST_SH_IR;
            `ST_SH_IR:  st_d = tms ? `ST_EX1_IR : `ST_SH_IR;
            `ST_EX1_IR: st_d = tms ? `ST_UPD_IR : `ST_PAU_IR;
            `ST_PAU_IR: st_d = tms ? `ST_EX2_IR : `ST_PAU_IR;
            `ST_EX2_IR: st_d = tms ? `ST_UPD_IR : `ST_SH_IR;
            `ST_UPD_IR: st_d = tms ? `ST_SEL_DR : `ST_IDLE;
            default:    st_d = `ST_RESET;
        endcase
    end

    // State advances on test clock rise; held in reset when disabled
    always @(posedge clk_i) begin
        if (!reset_n_i || !tap_en) begin
            st_q <= `ST_RESET;
        end else if (tck_rise) begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------
    // Instruction register
    // ----------------------------------------
    reg [`IR_W-1:0] ir_sh_q;
    reg [`IR_W-1:0] ir_q;

    // Capture, shift LSB first, update
    always @(posedge clk_i) begin
        if (!reset_n_i || !tap_en) begin
            ir_sh_q <= `IR_CAPTURE;
            ir_q    <= `OP_IDCODE;
        end else if (tck_rise) begin
            if (st_q == `ST_RESET) begin
                ir_q <= `OP_IDCODE;
            end
            if (st_q == `ST_CAP_IR) begin
                ir_sh_q <= `IR_CAPTURE;
            end else if (st_q == `ST_SH_IR) begin
                ir_sh_q <= {tdi, ir_sh_q[`IR_W-1:1]};
            end else if (st_q == `ST_UPD_IR) begin
                ir_q <= ir_sh_q;
            end
        end
    end

    // ----------------------------------------
    // Instruction decode
    // ----------------------------------------
    wire sel_extest = (ir_q == `OP_EXTEST);
    wire sel_idcode = (ir_q == `OP_IDCODE);
    wire sel_sample = (ir_q == `OP_SAMPLE);
    wire sel_devrst = (ir_q == `OP_DEVRST);
    wire sel_bsr    = sel_extest | sel_sample;
    // Private group: top bits 10 of the opcode
    wire sel_priv   = ((ir_q & `PRIV_MASK) == `OP_PRIV0);
    // Unknown opcodes fall back to bypass
    wire sel_bypass = ~(sel_idcode | sel_bsr | sel_devrst | sel_priv);

    assign private_op_o  = tap_en & sel_priv;
    assign private_sel_o = ir_q[1:0];

    // ----------------------------------------
    // Data registers
    // ----------------------------------------
    reg                 byp_q;
    reg [`ID_W-1:0]     id_sh_q;
    reg                 rst_reg_q;
    reg [`BSR_W-1:0]    bsr_sh_q;
    reg [`BSR_W-1:0]    bsr_lat_q;
    reg [`COMM_W-1:0]   comm_sh_q;
    reg [`COMM_W-1:0]   comm_q;
    reg                 dirty_q;
    wire [`ID_W-1:0]    id_val;

    // Version tracks silicon revision; bit 0 fixed one
    assign id_val[`ID_VER_MSB:`ID_VER_LSB]   = SILICON_REV;
    assign id_val[`ID_PART_MSB:`ID_PART_LSB] = `ID_PART_VAL;
    assign id_val[`ID_MFR_MSB:`ID_MFR_LSB]   = `ID_MFR_VAL;
    assign id_val[`ID_ONE_BIT]               = 1'b1;

    wire cap_dr = tck_rise & (st_q == `ST_CAP_DR);
    wire sh_dr  = tck_rise & (st_q == `ST_SH_DR);
    wire upd_dr = tck_rise & (st_q == `ST_UPD_DR);

    // All data paths but the reset cell: capture then shift LSB first toward TDO
    always @(posedge clk_i) begin
        if (!reset_n_i || !tap_en) begin
            byp_q     <= 1'b0;
            id_sh_q   <= {`ID_W{1'b0}};
            rst_reg_q <= 1'b0;
            bsr_sh_q  <= {`BSR_W{1'b0}};
            bsr_lat_q <= {`BSR_W{1'b0}};
            comm_sh_q <= `COMM_RESET;
        end else begin
            if (cap_dr && sel_bypass) begin
                byp_q <= 1'b0;
            end else if (sh_dr && sel_bypass) begin
                byp_q <= tdi;
            end
            if (cap_dr && sel_idcode) begin
                id_sh_q <= id_val;
            end else if (sh_dr && sel_idcode) begin
                id_sh_q <= {tdi, id_sh_q[`ID_W-1:1]};
            end
            // Reset cell shifts directly, no update latch
            if (sh_dr && sel_devrst) begin
                rst_reg_q <= tdi;
            end
            // Pin snapshot, core keeps running
            if (cap_dr && sel_bsr) begin
                bsr_sh_q <= pin_in_i;
            end else if (sh_dr && sel_bsr) begin
                bsr_sh_q <= {tdi, bsr_sh_q[`BSR_W-1:1]};
            end
            if (upd_dr && sel_bsr) begin
                bsr_lat_q <= bsr_sh_q;
            end
            // Debugger reads the communication byte via any of private ops 8..B
            if (cap_dr && sel_priv) begin
                comm_sh_q <= comm_q;
            end else if (sh_dr && sel_priv) begin
                comm_sh_q <= {tdi, comm_sh_q[`COMM_W-1:1]};
            end
        end
    end

    // ----------------------------------------
    // TDO output
    // ----------------------------------------
    reg tdo_q;
    reg tdo_oe_q;
    reg tdo_d;

    always @* begin
        tdo_d = byp_q;
        if (st_q == `ST_SH_IR) begin
            tdo_d = ir_sh_q[0];
        end else if (sel_idcode) begin
            tdo_d = id_sh_q[0];
        end else if (sel_devrst) begin
            tdo_d = rst_reg_q;
        end else if (sel_bsr) begin
            tdo_d = bsr_sh_q[0];
        end else if (sel_priv) begin
            tdo_d = comm_sh_q[0];
        end
    end

    // TDO changes on the falling test clock; floats when not shifting
    always @(posedge clk_i) begin
        if (!reset_n_i || !tap_en) begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else if (tck_fall) begin
            tdo_q    <= tdo_d;
            tdo_oe_q <= (st_q == `ST_SH_DR) || (st_q == `ST_SH_IR);
        end
    end
    assign tdo_o    = tdo_q;
    assign tdo_oe_o = tdo_oe_q;

    // ----------------------------------------
    // Device reset and pin drive
    // ----------------------------------------
    wire rst_req = tap_en & sel_devrst & rst_reg_q;

    reset_stretch u_rst (
        .clk_i       (clk_i),
        .reset_n_i   (reset_n_i),
        .rst_req_i   (rst_req),
        .timeout_i   (reset_timeout_i),
        .dev_reset_o (dev_reset_o)
    );

    // EXTEST drives latches straight away; otherwise reset floats every pin
    wire extest_on = tap_en & sel_extest;
    assign pin_out_o = extest_on ? bsr_lat_q : core_out_i;
    assign pin_oe_o  = extest_on ? {`BSR_W{1'b1}} :
                       (dev_reset_o ? {`BSR_W{1'b0}} : core_oe_i);

    // ----------------------------------------
    // Debug communication register
    // ----------------------------------------
    reg [`COMM_W-1:0] rdata_q;
    wire              comm_sel;

    // Shared location: only with fuse and debugger enable
    assign comm_sel     = debug_enable_fuse_i & dbg_access_en_i;
    assign io_reg_sel_o = cpu_sel_i & ~comm_sel;
    wire comm_wr = cpu_sel_i & cpu_wr_i & comm_sel;

    // Write sets dirty; a write in the clear cycle wins
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            comm_q  <= `COMM_RESET;
            dirty_q <= 1'b0;
        end else begin
            if (comm_wr) begin
                comm_q  <= cpu_wdata_i;
                dirty_q <= 1'b1;
            end else if (dbg_dirty_clr_i) begin
                dirty_q <= 1'b0;
            end
        end
    end

    // Read data registered: seven low bits plus dirty flag
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            rdata_q <= `COMM_RESET;
        end else if (cpu_sel_i && cpu_rd_i && comm_sel) begin
            rdata_q <= {dirty_q, comm_q[`COMM_DIRTY_BIT-1:0]};
        end
    end
    assign cpu_rdata_o     = rdata_q;
    assign dbg_comm_data_o = comm_q;

    // ----------------------------------------
    // Fuse programming guard
    // ----------------------------------------
    reg erased_q;

    // Lock bits block debug fuse until a chip erase is seen
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            erased_q <= 1'b0;
        end else if (chip_erase_i) begin
            erased_q <= 1'b1;
        end
    end
    assign fuse_prog_ok_o = fuse_prog_req_i & tap_en &
        (~(lock_bit_one_i | lock_bit_two_i) | erased_q);
endmodule // jtag_test_data_registers

// [hdl/tdr_defs.vh]
`ifndef TDR_DEFS_VH
`define TDR_DEFS_VH

// ----------------------------------------
// Instruction opcodes
// ----------------------------------------
`define IR_W            4
`define OP_EXTEST       4'h0
`define OP_IDCODE       4'h1
`define OP_SAMPLE       4'h2
`define OP_PRIV0        4'h8
`define OP_PRIV1        4'h9
`define OP_PRIV2        4'hA
`define OP_PRIV3        4'hB
`define OP_DEVRST       4'hC
`define OP_BYPASS       4'hF
`define PRIV_MASK       4'hC
`define IR_CAPTURE      4'h1

// ----------------------------------------
// Identification register layout
// ----------------------------------------
`define ID_W            32
`define ID_VER_MSB      31
`define ID_VER_LSB      28
`define ID_PART_MSB     27
`define ID_PART_LSB     12
`define ID_MFR_MSB      11
`define ID_MFR_LSB      1
`define ID_ONE_BIT      0
// Arbitrary neutral identity values
`define ID_PART_VAL     16'h1234
`define ID_MFR_VAL      11'h2AA

// ----------------------------------------
// Communication register and misc
// ----------------------------------------
`define COMM_W          8
`define COMM_DIRTY_BIT  7
`define COMM_RESET      8'h00
`define BSR_W           8
`define RST_TIMEOUT     16'h0040
`define TO_W            16

// ----------------------------------------
// TAP states
// ----------------------------------------
`define ST_RESET        4'h0
`define ST_IDLE         4'h1
`define ST_SEL_DR       4'h2
`define ST_CAP_DR       4'h3
`define ST_SH_DR        4'h4
`define ST_EX1_DR       4'h5
`define ST_PAU_DR       4'h6
`define ST_EX2_DR       4'h7
`define ST_UPD_DR       4'h8
`define ST_SEL_IR       4'h9
`define ST_CAP_IR       4'hA
`define ST_SH_IR        4'hB
`define ST_EX1_IR       4'hC
`define ST_PAU_IR       4'hD
`define ST_EX2_IR       4'hE
`define ST_UPD_IR       4'hF

`endif

// [hdl/pin_sync.v]
`timescale 1ns/1ps
// ----------------------------------------
// Two-stage synchroniser per bit
// ----------------------------------------
module pin_sync #(
    parameter W = 3
) (
    input  wire         clk_i,
    input  wire         reset_n_i,
    input  wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            reg meta_q;
            reg sync_q;
            // First stage read only by second
            always @(posedge clk_i) begin
                if (!reset_n_i) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= async_i[g];
                    sync_q <= meta_q;
                end
            end
            assign sync_o[g] = sync_q;
        end
    endgenerate
endmodule // pin_sync

// [hdl/reset_stretch.v]
`timescale 1ns/1ps
`include "tdr_defs.vh"
// ----------------------------------------
// Reset hold with time-out after release
// ----------------------------------------
module reset_stretch (
    input  wire                 clk_i,
    input  wire                 reset_n_i,
    input  wire                 rst_req_i,
    input  wire [`TO_W-1:0]     timeout_i,
    output wire                 dev_reset_o
);
    reg [`TO_W-1:0] cnt_q;

    // Reload while requested, count down after release
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            cnt_q <= {`TO_W{1'b0}};
        end else if (rst_req_i) begin
            cnt_q <= timeout_i;
        end else if (cnt_q != {`TO_W{1'b0}}) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // Request acts at once, unlatched
    assign dev_reset_o = rst_req_i | (cnt_q != {`TO_W{1'b0}});
endmodule // reset_stretch

// [dv/tdr_monitor.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module tdr_monitor (
    input logic        clk_i,
    input logic        reset_n_i,
    input logic        tdo_oe_o,
    input logic        test_port_enable_fuse_i,
    input logic        test_port_disable_bit_i,
    input logic        debug_enable_fuse_i,
    input logic        lock_bit_one_i,
    input logic        lock_bit_two_i,
    input logic        chip_erase_i,
    input logic        fuse_prog_req_i,
    input logic        fuse_prog_ok_o,
    input logic        dbg_access_en_i,
    input logic [7:0]  dbg_comm_data_o,
    input logic        cpu_sel_i,
    input logic        cpu_wr_i,
    input logic        cpu_rd_i,
    input logic [7:0]  cpu_wdata_i,
    input logic [7:0]  cpu_rdata_o,
    input logic        io_reg_sel_o,
    input logic [7:0]  pin_oe_o,
    input logic        dev_reset_o,
    input logic [15:0] reset_timeout_i
);
    logic        tap_en, dbg_path, erased_q;
    logic [15:0] hi_cnt_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    // Access conditions at the pins
    assign tap_en   = test_port_enable_fuse_i & ~test_port_disable_bit_i;
    assign dbg_path = debug_enable_fuse_i & dbg_access_en_i;

    // Sticky erase; length of each reset pulse
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            erased_q <= 1'b0;
            hi_cnt_q <= 16'h0000;
        end else begin
            erased_q <= erased_q | chip_erase_i;
            hi_cnt_q <= dev_reset_o ? hi_cnt_q + 16'h0001 : 16'h0000;
        end
    end

    property p_prog_gate;
        fuse_prog_ok_o |-> fuse_prog_req_i && tap_en &&
            (!(lock_bit_one_i || lock_bit_two_i) || erased_q);
    endproperty
    a_prog_gate: assert property (p_prog_gate)
        else $error("fuse grant while locked");
    property p_prog_open;
        fuse_prog_req_i && tap_en && !lock_bit_one_i && !lock_bit_two_i
            |-> fuse_prog_ok_o;
    endproperty
    a_prog_open: assert property (p_prog_open)
        else $error("fuse refused while open");
    // Output enable falls a cycle late; allow margin
    property p_tap_off;
        (!tap_en) [*6] |-> !tdo_oe_o;
    endproperty
    a_tap_off: assert property (p_tap_off)
        else $error("tdo driven while disabled");
    property p_io_route;
        cpu_sel_i |-> io_reg_sel_o == !dbg_path;
    endproperty
    a_io_route: assert property (p_io_route)
        else $error("wrong routing");
    property p_store;
        cpu_sel_i && cpu_wr_i && dbg_path |=>
            dbg_comm_data_o == $past(cpu_wdata_i);
    endproperty
    a_store: assert property (p_store)
        else $error("byte not stored");
    property p_read;
        cpu_sel_i && cpu_rd_i && !cpu_wr_i && dbg_path |=>
            cpu_rdata_o[6:0] == $past(dbg_comm_data_o[6:0]);
    endproperty
    a_read: assert property (p_read)
        else $error("read bits wrong");
    property p_hold;
        !(cpu_sel_i && cpu_wr_i && dbg_path) |=> $stable(dbg_comm_data_o);
    endproperty
    a_hold: assert property (p_hold)
        else $error("byte changed without write");
    property p_reset_float;
        dev_reset_o && pin_oe_o != 8'hFF |-> pin_oe_o == 8'h00;
    endproperty
    a_reset_float: assert property (p_reset_float)
        else $error("pin driven in reset");
    property p_stretch;
        dev_reset_o ##1 !dev_reset_o |-> hi_cnt_q >= reset_timeout_i;
    endproperty
    a_stretch: assert property (p_stretch)
        else $error("reset shorter than time-out");

    c_write: cover property (cpu_sel_i && cpu_wr_i && dbg_path);
    c_reset: cover property (dev_reset_o ##1 !dev_reset_o);
    c_erase: cover property (fuse_prog_ok_o && lock_bit_one_i);
endmodule // tdr_monitor

bind jtag_test_data_registers tdr_monitor i_tdr_monitor (
    .clk_i, .reset_n_i, .tdo_oe_o, .test_port_enable_fuse_i,
    .test_port_disable_bit_i, .debug_enable_fuse_i, .lock_bit_one_i,
    .lock_bit_two_i, .chip_erase_i, .fuse_prog_req_i, .fuse_prog_ok_o,
    .dbg_access_en_i, .dbg_comm_data_o, .cpu_sel_i, .cpu_wr_i, .cpu_rd_i,
    .cpu_wdata_i, .cpu_rdata_o, .io_reg_sel_o, .pin_oe_o, .dev_reset_o,
    .reset_timeout_i
);

// [dv/tap_host.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Test controller model
// ----------------------------------------
module tap_host (
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    input  wire  tdo_i
);
    // Clock low between frames, data idles high
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
    end

    // One 800 ns test clock; TDO sampled before the rise
    task automatic step(input logic ms, input logic di, output logic so);
        tms_o = ms;
        tdi_o = di;
        #400;
        so = tdo_i;
        tck_o = 1'b1;
        #400;
        tck_o = 1'b0;
    endtask

    // Five ones reach reset, then idle
    task automatic walk_reset;
        logic s;
        repeat (5) step(1'b1, 1'b1, s);
        step(1'b0, 1'b1, s);
    endtask

    // Idle to shift, n bits, update, idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic s;
        dout = 32'h0;
        step(1'b1, 1'b1, s);
        if (ir)
            step(1'b1, 1'b1, s);
        step(1'b0, 1'b1, s);
        step(1'b0, 1'b1, s);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], s);
            dout[i] = s;
        end
        step(1'b1, 1'b1, s);
        step(1'b0, 1'b1, s);
    endtask
endmodule // tap_host

// [dv/tb.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Self-checking bench
// ----------------------------------------
module tb;
    localparam logic [3:0]  REV  = 4'h3;
    localparam logic [15:0] TOUT = 16'h0028;
    localparam logic [31:0] ID   = {REV, 16'h1234, 11'h2AA, 1'b1};
    logic        clk_i, reset_n_i, tck, tms, tdi, tdo, tdo_oe, oe_seen;
    logic        en_f, dis_b, dbg_f, lb1, lb2, erase, p_req, p_ok;
    logic        acc_en, d_clr, sel, wr, rd, io_sel, priv, dev_rst;
    logic [1:0]  priv_sel;
    logic [7:0]  comm, wdata, rdata, pin_in, c_out, c_oe, pin_out, pin_oe;
    logic [31:0] dout, v;
    wire         tdo_w;
    integer      seed = 32'h427b;
    integer      mismatches = 0, cmp_count = 0;
    int          m_byte = 0, m_dirty = 0;

    // Released output reads as its pull-up
    assign tdo_w = tdo_oe ? tdo : 1'b1;

    jtag_test_data_registers #(.SILICON_REV(REV))
        i_jtag_test_data_registers (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .tck_i(tck), .tms_i(tms),
        .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
        .test_port_enable_fuse_i(en_f), .test_port_disable_bit_i(dis_b),
        .debug_enable_fuse_i(dbg_f), .lock_bit_one_i(lb1),
        .lock_bit_two_i(lb2), .chip_erase_i(erase),
        .fuse_prog_req_i(p_req), .fuse_prog_ok_o(p_ok),
        .dbg_access_en_i(acc_en), .dbg_dirty_clr_i(d_clr),
        .dbg_comm_data_o(comm), .cpu_sel_i(sel), .cpu_wr_i(wr),
        .cpu_rd_i(rd), .cpu_wdata_i(wdata), .cpu_rdata_o(rdata),
        .io_reg_sel_o(io_sel), .pin_in_i(pin_in), .core_out_i(c_out),
        .core_oe_i(c_oe), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
        .private_op_o(priv), .private_sel_o(priv_sel),
        .dev_reset_o(dev_rst), .reset_timeout_i(TOUT)
    );
    tap_host i_tap_host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_w));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // Catch any drive of the test output
    always @(posedge clk_i)
        if (tdo_oe === 1'b1) oe_seen = 1'b1;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic dr(input int n, input logic [31:0] d);
        i_tap_host.scan(1'b0, n, d, dout);
    endtask

    task automatic ir(input logic [3:0] op);
        i_tap_host.scan(1'b1, 4, {28'h0, op}, dout);
        check(dout[3:0], 4'h1);
    endtask

    // One CPU access; model tracks byte and dirty flag
    task automatic cpu(input logic w, input logic [7:0] d);
        @(negedge clk_i);
        {sel, wr, rd, wdata} = {1'b1, w, ~w, d};
        @(negedge clk_i);
        check(io_sel, !(dbg_f && acc_en));
        if (dbg_f && acc_en && w) begin
            m_byte = d;
            m_dirty = 1;
        end
        if (dbg_f && acc_en && !w)
            check(rdata, {m_dirty[0], m_byte[6:0]});
        check(comm, m_byte[7:0]);
        {sel, wr, rd} = 3'b000;
    endtask

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Run needs under half a millisecond
    initial begin
        #3000000;
        mismatches++;
        wrap_up;
    end

    initial begin
        reset_n_i = 1'b0;
        oe_seen = 1'b0;
        {en_f, dis_b, dbg_f, lb1, lb2, erase, p_req} = 7'b1000000;
        {acc_en, d_clr, sel, wr, rd} = 5'b00000;
        {wdata, pin_in, c_out, c_oe} = 32'h0;
        repeat (4) @(negedge clk_i);
        reset_n_i = 1'b1;
        repeat (3) @(negedge clk_i);
        i_tap_host.walk_reset();
        dr(32, $random(seed));
        check(dout, ID);
        // All routings: write, read, clear, read again
        for (int k = 0; k < 4; k++) begin
            @(negedge clk_i);
            {dbg_f, acc_en} = k[1:0];
            v = $random(seed);
            cpu(1'b1, v[7:0]);
            cpu(1'b0, 8'h00);
            @(negedge clk_i);
            d_clr = 1'b1;
            m_dirty = 0;
            @(negedge clk_i);
            d_clr = 1'b0;
            cpu(1'b0, 8'h00);
        end
        // Private opcodes carry the stored byte
        for (int op = 8; op < 12; op++) begin
            ir(op[3:0]);
            check({priv, priv_sel}, {1'b1, op[1:0]});
            dr(8, $random(seed));
            check(dout[7:0], m_byte[7:0]);
        end
        ir(4'hF);
        check(priv, 1'b0);
        v = $random(seed);
        dr(8, v);
        check(dout[7:0], {v[6:0], 1'b0});
        // Snapshot leaves pins alone; preload safe values first
        @(negedge clk_i);
        {c_out, c_oe, pin_in} = $random(seed);
        ir(4'h2);
        v = $random(seed);
        dr(8, v);
        check(dout[7:0], pin_in);
        check({pin_out, pin_oe}, {c_out, c_oe});
        ir(4'h0);
        check({pin_out, pin_oe}, {v[7:0], 8'hFF});
        @(negedge clk_i);
        pin_in = $random(seed);
        dr(8, v);
        check(dout[7:0], pin_in);
        // Reset register: hold at once, stretched release
        ir(4'hC);
        dr(1, 32'h1);
        check({dev_rst, pin_oe}, 9'h100);
        dr(1, 32'h0);
        check({dout[0], dev_rst}, 2'b11);
        repeat (TOUT) @(negedge clk_i);
        check(dev_rst, 1'b0);
        // Lock bits block fuse programming till erase
        p_req = 1'b1;
        for (int k = 0; k < 4; k++) begin
            @(negedge clk_i);
            {lb1, lb2} = k[1:0];
            @(negedge clk_i);
            check(p_ok, k == 0);
        end
        erase = 1'b1;
        @(negedge clk_i);
        erase = 1'b0;
        @(negedge clk_i);
        check(p_ok, 1'b1);
        // Port dead by fuse or disable bit, IDCODE after
        for (int k = 0; k < 2; k++) begin
            ir(4'hF);
            @(negedge clk_i);
            {en_f, dis_b} = k ? 2'b00 : 2'b11;
            oe_seen = 1'b0;
            dr(32, $random(seed));
            check({oe_seen, p_ok}, 2'b00);
            @(negedge clk_i);
            {en_f, dis_b} = 2'b10;
            repeat (4) @(negedge clk_i);
            i_tap_host.walk_reset();
            dr(32, $random(seed));
            check(dout, ID);
        end
        wrap_up;
    end
endmodule // tb
